/* parallel_interface_unit.sv */
// programmable parallel port unit with basic, strobed and bidir modes
`timescale 1ns/1ps
`default_nettype none
module parallel_interface_unit (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // host register port
   input wire logic [1:0] hostAddress,
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [7:0] hostWriteData,
   output logic [7:0] hostReadData,
   // port a pins
   input wire logic [7:0] portAIn,
   output logic [7:0] portAOut,
   output logic [7:0] portAOe,
   // port b pins
   input wire logic [7:0] portBIn,
   output logic [7:0] portBOut,
   output logic [7:0] portBOe,
   // port c pins
   input wire logic [7:0] portCIn,
   output logic [7:0] portCOut,
   output logic [7:0] portCOe
);
   // ------------------------------------------------------------
   // control word and mode decode
   // ------------------------------------------------------------
   logic [7:0] control;
   logic [7:0] cLatch;
   logic [7:0] aOut;
   logic [7:0] bOut;
   logic [7:0] aIn;
   logic [7:0] bIn;
   logic [7:0] hsMask;
   logic [7:0] statusC;
   logic [7:0] pinC;
   logic [7:0] driveC;
   logic [7:0] next_readData;
   parallel_port_pkg::groupMode_type modeA;
   logic modeWrite;
   logic bitWrite;
   logic aStrobedIn;
   logic aStrobedOut;
   logic aBidir;
   logic bStrobed;
   logic bStrobedIn;
   logic bStrobedOut;
   logic aLatchNow;
   logic aInFull;
   logic aOutFullN;
   logic aIrq;
   logic bLatchNow;
   logic bInFull;
   logic bOutFullN;
   logic bIrq;
   logic [2:0] bitSelect;

   // group a mode from bits 6..5; 1x is bidirectional
   function automatic parallel_port_pkg::groupMode_type groupAMode(
      input logic [7:0] cw);
      if (cw[parallel_port_pkg::CW_A_MODE_HI]) begin
         return parallel_port_pkg::MODE_BIDIR;
      end else if (cw[parallel_port_pkg::CW_A_MODE_LO]) begin
         return parallel_port_pkg::MODE_STROBED;
      end
      return parallel_port_pkg::MODE_BASIC;
   endfunction

   // true when the address matches one unit offset
   function automatic logic hit(input logic [1:0] address,
      input logic [1:0] offset);
      return address == offset;
   endfunction

   // bit 7 separates mode words from bit commands
   assign modeWrite = hostWrite
      && hit(hostAddress, parallel_port_pkg::CONTROL_OFFSET)
      && hostWriteData[parallel_port_pkg::CW_MODE_FLAG];
   assign bitWrite = hostWrite
      && hit(hostAddress, parallel_port_pkg::CONTROL_OFFSET)
      && !hostWriteData[parallel_port_pkg::CW_MODE_FLAG];
   assign bitSelect = hostWriteData[parallel_port_pkg::BSR_SELECT_HI:
      parallel_port_pkg::BSR_SELECT_LO];

   // group decode; bidir exists for group a only
   assign modeA = groupAMode(control);
   assign aStrobedIn = (modeA == parallel_port_pkg::MODE_STROBED)
      && control[parallel_port_pkg::CW_A_INPUT];
   assign aStrobedOut = (modeA == parallel_port_pkg::MODE_STROBED)
      && !control[parallel_port_pkg::CW_A_INPUT];
   assign aBidir = (modeA == parallel_port_pkg::MODE_BIDIR);
   assign bStrobed = control[parallel_port_pkg::CW_B_MODE];
   // port b strobed input from bits 2 and 1
   assign bStrobedIn = bStrobed && control[parallel_port_pkg::CW_B_INPUT];
   assign bStrobedOut = bStrobed && !control[parallel_port_pkg::CW_B_INPUT];

   // mode word; reset leaves every port an input, nothing driven
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         control <= parallel_port_pkg::CONTROL_RESET;
      end else if (modeWrite) begin
         control <= hostWriteData;
      end
   end

   // ------------------------------------------------------------
   // port c latch and handshake mask
   // ------------------------------------------------------------
   // handshake lines taken per mode
   always_comb begin
      hsMask = 8'h00;
      case (modeA)
         parallel_port_pkg::MODE_STROBED: begin
            hsMask[parallel_port_pkg::PC_A_REQUEST] = 1'b1;
            if (aStrobedIn) begin
               hsMask[parallel_port_pkg::PC_A_IN_FULL] = 1'b1;
               hsMask[parallel_port_pkg::PC_A_STROBE] = 1'b1;
            end else begin
               hsMask[parallel_port_pkg::PC_A_OUT_FULL] = 1'b1;
               hsMask[parallel_port_pkg::PC_A_ACK] = 1'b1;
            end
         end
         parallel_port_pkg::MODE_BIDIR: begin
            hsMask[7:3] = 5'h1F;
         end
         parallel_port_pkg::MODE_BASIC: begin
            hsMask[7:3] = 5'h00;
         end
         default: begin
            hsMask[7:3] = 5'h00;
         end
      endcase
      if (bStrobed) begin
         hsMask[2:0] = 3'h7;
      end
   end

   // single bit set/reset; also the enable flags
   // direct writes reach only spare lines, handshake bits kept
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cLatch <= parallel_port_pkg::LATCH_RESET;
      end else if (modeWrite) begin
         cLatch <= parallel_port_pkg::LATCH_RESET;
      end else if (bitWrite) begin
         cLatch[bitSelect] <= hostWriteData[parallel_port_pkg::BSR_VALUE];
      end else if (hostWrite
         && hit(hostAddress, parallel_port_pkg::PORT_C_OFFSET)) begin
         cLatch <= (cLatch & hsMask) | (hostWriteData & ~hsMask);
      end
   end

   // ------------------------------------------------------------
   // data latches
   // ------------------------------------------------------------
   // output latches, cleared by a mode word
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         aOut <= parallel_port_pkg::LATCH_RESET;
         bOut <= parallel_port_pkg::LATCH_RESET;
      end else if (modeWrite) begin
         aOut <= parallel_port_pkg::LATCH_RESET;
         bOut <= parallel_port_pkg::LATCH_RESET;
      end else if (hostWrite) begin
         if (hit(hostAddress, parallel_port_pkg::PORT_A_OFFSET)) begin
            aOut <= hostWriteData;
         end
         if (hit(hostAddress, parallel_port_pkg::PORT_B_OFFSET)) begin
            bOut <= hostWriteData;
         end
      end
   end

   // strobed input data caught on the strobe edge
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         aIn <= parallel_port_pkg::LATCH_RESET;
         bIn <= parallel_port_pkg::LATCH_RESET;
      end else begin
         if (aLatchNow) begin
            aIn <= portAIn;
         end
         if (bLatchNow) begin
            bIn <= portBIn;
         end
      end
   end

   // ------------------------------------------------------------
   // handshake groups
   // ------------------------------------------------------------
   // enables live in c bits 4, 6 and 2
   strobe_channel groupAChannel (
      .clock(clock),
      .rst_b(rst_b),
      .clear(modeWrite),
      .inputSide(aStrobedIn || aBidir),
      .outputSide(aStrobedOut || aBidir),
      .inIrqEnable(cLatch[parallel_port_pkg::PC_A_STROBE]),
      .outIrqEnable(cLatch[parallel_port_pkg::PC_A_ACK]),
      .strobeN(portCIn[parallel_port_pkg::PC_A_STROBE]),
      .ackN(portCIn[parallel_port_pkg::PC_A_ACK]),
      .hostRead(hostRead
         && hit(hostAddress, parallel_port_pkg::PORT_A_OFFSET)),
      .hostWrite(hostWrite
         && hit(hostAddress, parallel_port_pkg::PORT_A_OFFSET)),
      .latchNow(aLatchNow),
      .inFull(aInFull),
      .outFullN(aOutFullN),
      .irqRequest(aIrq)
   );

   // group b shares one line for strobe or acknowledge
   strobe_channel groupBChannel (
      .clock(clock),
      .rst_b(rst_b),
      .clear(modeWrite),
      .inputSide(bStrobedIn),
      .outputSide(bStrobedOut),
      .inIrqEnable(cLatch[parallel_port_pkg::PC_B_STROBE]),
      .outIrqEnable(cLatch[parallel_port_pkg::PC_B_STROBE]),
      .strobeN(portCIn[parallel_port_pkg::PC_B_STROBE]),
      .ackN(portCIn[parallel_port_pkg::PC_B_STROBE]),
      .hostRead(hostRead
         && hit(hostAddress, parallel_port_pkg::PORT_B_OFFSET)),
      .hostWrite(hostWrite
         && hit(hostAddress, parallel_port_pkg::PORT_B_OFFSET)),
      .latchNow(bLatchNow),
      .inFull(bInFull),
      .outFullN(bOutFullN),
      .irqRequest(bIrq)
   );

   // ------------------------------------------------------------
   // port c status and pins
   // ------------------------------------------------------------
   // status shows enables, never strobe levels
   always_comb begin
      statusC = (control[parallel_port_pkg::CW_C_UPPER_INPUT]
         ? {portCIn[7:4], 4'h0} : {cLatch[7:4], 4'h0})
         | (control[parallel_port_pkg::CW_C_LOWER_INPUT]
         ? {4'h0, portCIn[3:0]} : {4'h0, cLatch[3:0]});
      pinC = cLatch;
      driveC = {{4{!control[parallel_port_pkg::CW_C_UPPER_INPUT]}},
         {4{!control[parallel_port_pkg::CW_C_LOWER_INPUT]}}} & ~hsMask;
      if (aStrobedOut || aBidir) begin
         statusC[parallel_port_pkg::PC_A_OUT_FULL] = aOutFullN;
         statusC[parallel_port_pkg::PC_A_ACK] =
            cLatch[parallel_port_pkg::PC_A_ACK];
         pinC[parallel_port_pkg::PC_A_OUT_FULL] = aOutFullN;
         driveC[parallel_port_pkg::PC_A_OUT_FULL] = 1'b1;
      end
      if (aStrobedIn || aBidir) begin
         statusC[parallel_port_pkg::PC_A_IN_FULL] = aInFull;
         statusC[parallel_port_pkg::PC_A_STROBE] =
            cLatch[parallel_port_pkg::PC_A_STROBE];
         pinC[parallel_port_pkg::PC_A_IN_FULL] = aInFull;
         driveC[parallel_port_pkg::PC_A_IN_FULL] = 1'b1;
      end
      if (modeA != parallel_port_pkg::MODE_BASIC) begin
         statusC[parallel_port_pkg::PC_A_REQUEST] = aIrq;
         pinC[parallel_port_pkg::PC_A_REQUEST] = aIrq;
         driveC[parallel_port_pkg::PC_A_REQUEST] = 1'b1;
      end
      if (bStrobed) begin
         statusC[2:0] = {cLatch[parallel_port_pkg::PC_B_STROBE],
            bStrobedIn ? bInFull : bOutFullN, bIrq};
         pinC[1:0] = {bStrobedIn ? bInFull : bOutFullN, bIrq};
         driveC[1:0] = 2'h3;
      end
   end

   assign portCOut = pinC;
   assign portCOe = driveC;

   // ------------------------------------------------------------
   // ports a and b pins, host read data
   // ------------------------------------------------------------
   // direction bits; bidir drives only during acknowledge
   assign portAOut = aOut;
   assign portAOe = aBidir ? (portCIn[parallel_port_pkg::PC_A_ACK]
      ? 8'h00 : parallel_port_pkg::ALL_ONES)
      : (control[parallel_port_pkg::CW_A_INPUT]
      ? 8'h00 : parallel_port_pkg::ALL_ONES);
   assign portBOut = bOut;
   assign portBOe = control[parallel_port_pkg::CW_B_INPUT]
      ? 8'h00 : parallel_port_pkg::ALL_ONES;

   // basic inputs read live, strobed inputs read the latch
   always_comb begin
      next_readData = hostReadData;
      case (hostAddress)
         parallel_port_pkg::PORT_A_OFFSET: begin
            if (modeA == parallel_port_pkg::MODE_BASIC) begin
               next_readData = control[parallel_port_pkg::CW_A_INPUT]
                  ? portAIn : aOut;
            end else begin
               next_readData = aStrobedOut ? aOut : aIn;
            end
         end
         parallel_port_pkg::PORT_B_OFFSET: begin
            if (!bStrobed) begin
               next_readData = control[parallel_port_pkg::CW_B_INPUT]
                  ? portBIn : bOut;
            end else begin
               next_readData = bStrobedIn ? bIn : bOut;
            end
         end
         parallel_port_pkg::PORT_C_OFFSET: begin
            next_readData = statusC;
         end
         default: begin
            next_readData = control;
         end
      endcase
   end

   // read data held until the next read
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hostReadData <= 8'h00;
      end else if (hostRead) begin
         hostReadData <= next_readData;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_mode_word_clears: assert property (
      modeWrite |=> cLatch == 8'h00 && aOut == 8'h00 && control[7])
      else $error("mode word did not reset latches");
   a_bit_cmd_lands: assert property (
      bitWrite |=> cLatch[$past(bitSelect)] == $past(hostWriteData[0]))
      else $error("bit command lost");
   a_basic_dir_a: assert property (
      modeA == parallel_port_pkg::MODE_BASIC && !control[4]
      |-> portAOe == 8'hFF)
      else $error("basic output port a not driven");
   a_live_input_read: assert property (
      hostRead && hostAddress == 2'h0 && control[4]
      && modeA == parallel_port_pkg::MODE_BASIC
      |=> hostReadData == $past(portAIn))
      else $error("basic input not read live");
   a_spare_in_mode: assert property (
      aStrobedIn |-> hsMask[7:6] == 2'b00 && hsMask[5:3] == 3'b111)
      else $error("strobed input spare lines wrong");
   a_spare_out_mode: assert property (
      aStrobedOut |-> hsMask[5:4] == 2'b00 && hsMask[7:6] == 2'b11)
      else $error("strobed output spare lines wrong");
   a_group_b_full: assert property (
      bStrobed |-> hsMask[2:0] == 3'b111 && driveC[2] == 1'b0)
      else $error("group b spare line left");
   a_status_no_strobe: assert property (
      aStrobedIn |-> statusC[4] == cLatch[4] && statusC[5] == aInFull)
      else $error("status shows strobe pin");
   a_b_strobe_decode: assert property (
      control[7] && control[2] && control[1] |-> bStrobedIn)
      else $error("port b strobed input not decoded");
endmodule // parallel_interface_unit
`default_nettype wire

/* parallel_port_pkg.sv */
// constants and types shared by the parallel interface unit
package parallel_port_pkg;
   // ------------------------------------------------------------
   // host port offsets inside one unit
   // ------------------------------------------------------------
   localparam logic [1:0] PORT_A_OFFSET = 2'h0;
   localparam logic [1:0] PORT_B_OFFSET = 2'h1;
   localparam logic [1:0] PORT_C_OFFSET = 2'h2;
   localparam logic [1:0] CONTROL_OFFSET = 2'h3;
   // board byte offsets of the port c status of each unit
   localparam logic [7:0] GROUP_A_PORT_C_STATUS = 8'h02;
   localparam logic [7:0] GROUP_B_UNIT_PORT_C_STATUS = 8'h06;
   localparam logic [7:0] THIRD_UNIT_PORT_C_STATUS = 8'h0A;
   localparam logic [7:0] FOURTH_UNIT_PORT_C_STATUS = 8'h0E;
   // ------------------------------------------------------------
   // control word fields
   // ------------------------------------------------------------
   localparam int CW_MODE_FLAG = 7;
   localparam int CW_A_MODE_HI = 6;
   localparam int CW_A_MODE_LO = 5;
   localparam int CW_A_INPUT = 4;
   localparam int CW_C_UPPER_INPUT = 3;
   localparam int CW_B_MODE = 2;
   localparam int CW_B_INPUT = 1;
   localparam int CW_C_LOWER_INPUT = 0;
   localparam int BSR_SELECT_HI = 3;
   localparam int BSR_SELECT_LO = 1;
   localparam int BSR_VALUE = 0;
   // ------------------------------------------------------------
   // port c handshake bit positions
   // ------------------------------------------------------------
   localparam int PC_A_OUT_FULL = 7;
   localparam int PC_A_ACK = 6;
   localparam int PC_A_IN_FULL = 5;
   localparam int PC_A_STROBE = 4;
   localparam int PC_A_REQUEST = 3;
   localparam int PC_B_STROBE = 2;
   localparam int PC_B_FULL = 1;
   localparam int PC_B_REQUEST = 0;
   // ------------------------------------------------------------
   // reset values and modes
   // ------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h9B;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   typedef enum logic [1:0] {
      MODE_BASIC = 2'b00,
      MODE_STROBED = 2'b01,
      MODE_BIDIR = 2'b10
   } groupMode_type;
endpackage

/* strobe_channel.sv */
// handshake flags of one strobed data group
`timescale 1ns/1ps
`default_nettype none
module strobe_channel (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // configuration
   input wire logic clear,
   input wire logic inputSide,
   input wire logic outputSide,
   input wire logic inIrqEnable,
   input wire logic outIrqEnable,
   // peripheral handshake pins
   input wire logic strobeN,
   input wire logic ackN,
   // host accesses to the data port
   input wire logic hostRead,
   input wire logic hostWrite,
   // flags
   output logic latchNow,
   output logic inFull,
   output logic outFullN,
   output logic irqRequest
);
   logic strobePrev;
   logic ackPrev;
   logic inReq;
   logic outReq;
   logic readPending;
   logic strobeEnd;
   logic ackFall;
   logic ackEnd;

   // edge history of the handshake pins
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         strobePrev <= 1'b1;
         ackPrev <= 1'b1;
      end else begin
         strobePrev <= strobeN;
         ackPrev <= ackN;
      end
   end

   assign latchNow = inputSide & strobePrev & ~strobeN;
   assign strobeEnd = inputSide & ~strobePrev & strobeN;
   assign ackFall = outputSide & ackPrev & ~ackN;
   assign ackEnd = outputSide & ~ackPrev & ackN;

   // buffer full drops one cycle after the read that emptied it
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         readPending <= 1'b0;
      end else begin
         readPending <= hostRead & inputSide & ~clear;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         inFull <= 1'b0;
      end else if (clear) begin
         inFull <= 1'b0;
      end else if (latchNow) begin
         inFull <= 1'b1;
      end else if (readPending) begin
         inFull <= 1'b0;
      end
   end

   // input request, a new strobe end beats a read
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         inReq <= 1'b0;
      end else if (clear) begin
         inReq <= 1'b0;
      end else if (strobeEnd && inFull) begin
         inReq <= 1'b1;
      end else if (hostRead) begin
         inReq <= 1'b0;
      end
   end

   // host write lowers the output full flag
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         outFullN <= 1'b1;
      end else if (clear) begin
         outFullN <= 1'b1;
      end else if (hostWrite && outputSide) begin
         outFullN <= 1'b0;
      end else if (ackFall) begin
         outFullN <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         outReq <= 1'b0;
      end else if (clear) begin
         outReq <= 1'b0;
      end else if (ackEnd && outFullN) begin
         outReq <= 1'b1;
      end else if (hostWrite) begin
         outReq <= 1'b0;
      end
   end

   // request visible only under its enable
   assign irqRequest = (inReq & inIrqEnable) | (outReq & outIrqEnable);

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence strobeFalls;
      inputSide && strobeN ##1 inputSide && !strobeN && !clear;
   endsequence

   a_strobe_sets_full: assert property (
      strobeFalls |=> inFull)
      else $error("strobe did not set input full");
   a_read_clears_full: assert property (
      (hostRead && inputSide && !clear && !latchNow) ##1 !latchNow
      |=> !inFull)
      else $error("read did not clear input full");
   a_write_lowers_obf: assert property (
      hostWrite && outputSide && !clear |=> !outFullN)
      else $error("write did not lower output full");
   a_ack_raises_obf: assert property (
      outputSide && ackN ##1 outputSide && !ackN && !hostWrite && !clear
      |=> outFullN)
      else $error("acknowledge did not raise output full");
   a_irq_needs_enable: assert property (
      !inIrqEnable && !outIrqEnable |-> !irqRequest)
      else $error("request without enable");
endmodule // strobe_channel
`default_nettype wire

/* peripheral_model.sv */
// peripheral model driving the strobed handshake pins
`timescale 1ns/1ps
`default_nettype none
module peripheral_model (
   // clock
   input wire logic clock,
   // pins toward the unit
   output logic [7:0] dataOut,
   output logic strobeN,
   output logic ackN
);
   // idle lines high, data bus driven with A5
   initial begin
      dataOut = 8'hA5;
      strobeN = 1'b1;
      ackN = 1'b1;
   end
   task automatic send(input logic [7:0] d);
      @(posedge clock);
      #1 dataOut = d;
      strobeN = 1'b0;
      @(posedge clock);
      #1 strobeN = 1'b1;
      @(posedge clock);
      // hold over: show inverse so stale data cannot match
      #1 dataOut = ~d;
   endtask
   task automatic ack();
      @(posedge clock);
      #1 ackN = 1'b0;
      @(posedge clock);
      #1 ackN = 1'b1;
   endtask
endmodule // peripheral_model
`default_nettype wire

/* testbench.sv */
// self-checking bench for the parallel interface unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] hostAddress = 2'h0;
   logic hostWrite = 1'b0;
   logic hostRead = 1'b0;
   logic [7:0] hostWriteData = 8'h00;
   logic [7:0] hostReadData, portAIn, portAOut, portAOe, portBOut;
   logic [7:0] portBOe, portCOut, portCOe, rd;
   logic strobeN, ackN;
   int miscompares = 0;
   int testsRun = 0;
   int cycles = 0;
   always #20 clock = ~clock;
   parallel_interface_unit DUT (.clock(clock), .rst_b(rst_b),
      .hostAddress(hostAddress), .hostWrite(hostWrite),
      .hostRead(hostRead), .hostWriteData(hostWriteData),
      .hostReadData(hostReadData), .portAIn(portAIn),
      .portAOut(portAOut), .portAOe(portAOe), .portBIn(8'h3C),
      .portBOut(portBOut), .portBOe(portBOe),
      .portCIn({1'b1, ackN, 1'b1, strobeN, 1'b1, strobeN, 2'h3}),
      .portCOut(portCOut), .portCOe(portCOe));
   peripheral_model peer (.clock(clock), .dataOut(portAIn),
      .strobeN(strobeN), .ackN(ackN));
   // one host access, released on the next edge
   task automatic acc(input logic w, input logic [1:0] a,
         input logic [7:0] d);
      @(posedge clock);
      #1 hostAddress = a;
      hostWrite = w;
      hostRead = ~w;
      hostWriteData = d;
      @(posedge clock);
      #1 hostWrite = 1'b0;
      hostRead = 1'b0;
      rd = hostReadData;
   endtask
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      testsRun++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, tests need about 80 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      #1 rst_b = 1'b1;
      chk(8'h00, portAOe);
      acc(1'b0, 2'h3, 8'h00);
      chk(8'h9B, rd);
      acc(1'b1, 2'h3, 8'h80);
      acc(1'b1, 2'h0, 8'h5A);
      chk(8'h5A, portAOut);
      chk(8'hFF, portAOe);
      acc(1'b1, 2'h1, 8'hC6);
      chk(8'hC6, portBOut);
      chk(8'hFF, portBOe);
      acc(1'b1, 2'h3, 8'h0F);
      chk(8'h80, portCOut);
      acc(1'b1, 2'h3, 8'h90);
      chk(8'h00, portAOe);
      acc(1'b0, 2'h0, 8'h00);
      chk(8'hA5, rd);
      acc(1'b1, 2'h3, 8'hB0);
      acc(1'b1, 2'h3, 8'h09);
      peer.send(8'hC3);
      acc(1'b0, 2'h2, 8'h00);
      chk(8'h38, rd);
      acc(1'b0, 2'h0, 8'h00);
      chk(8'hC3, rd);
      acc(1'b0, 2'h2, 8'h00);
      chk(8'h10, rd);
      acc(1'b1, 2'h3, 8'hA0);
      acc(1'b1, 2'h3, 8'h0D);
      acc(1'b1, 2'h0, 8'h69);
      acc(1'b0, 2'h2, 8'h00);
      chk(8'h40, rd);
      peer.ack();
      acc(1'b0, 2'h2, 8'h00);
      chk(8'hC8, rd);
      // both groups strobed input, group b enabled through bit 2
      acc(1'b1, 2'h3, 8'hB6);
      acc(1'b1, 2'h3, 8'h05);
      chk(8'hEB, portCOe);
      peer.send(8'h96);
      acc(1'b0, 2'h2, 8'h00);
      chk(8'h27, rd);
      acc(1'b0, 2'h1, 8'h00);
      chk(8'h3C, rd);
      acc(1'b0, 2'h0, 8'h00);
      chk(8'h96, rd);
      // bidirectional port a, output enable only
      acc(1'b1, 2'h3, 8'hC0);
      acc(1'b1, 2'h3, 8'h0D);
      acc(1'b1, 2'h0, 8'h3E);
      chk(8'h00, portAOe);
      peer.send(8'h5B);
      acc(1'b0, 2'h2, 8'h00);
      chk(8'h60, rd);
      acc(1'b0, 2'h0, 8'h00);
      chk(8'h5B, rd);
      peer.ack();
      acc(1'b0, 2'h2, 8'h00);
      chk(8'hC8, rd);
      conclude();
   end
endmodule // testbench
`default_nettype wire
